/* File: logic/dcbff_pkg.sv */
// shared constants, pin bundle type and gray helpers for the bidirectional fifo
// assumes one system clock samples every pin; no bus, all controls are plain pins
// Function
// - half-full high at 256+, low at 255-
// - half-full low after queue reset
// - input-ready moves on writer clock; low blocks writes
// - input-ready low in reset, high second edge
// - output-ready on reader clock; low keeps last word
// - output-ready rises third reader edge after fill
// - first word falls through with output-ready
// - ready flags cross two stages into port
// - reset: half-full, ready flags low, almost high
// - read pops when selected, enabled, output-ready
// - write pushes when selected, enabled, input-ready
// - data driven only when selected for read
// - almost flag at X- or 512-Y+ words
// - offsets programmed after reset, before first write
// - first program edge stores low byte X,Y
// - second program edge overwrites Y only
// - offsets eight bits, largest 255
// - unprogrammed offsets default to 128
// - program edges store no data word
package dcbff_pkg;
   // data path
   localparam int DATA_W = 18;
   localparam int ADDR_W = 9;
   localparam int DEPTH = 512;
   // flag thresholds and offsets
   localparam logic [ADDR_W:0] HALF_LEVEL = 10'h100;
   localparam logic [ADDR_W:0] FULL_LEVEL = 10'h200;
   localparam int OFFSET_W = 8;
   localparam logic [OFFSET_W-1:0] OFFSET_DEFAULT = 8'h80;
   // program edge counter saturates here
   localparam logic [1:0] PROG_DONE = 2'h2;

   // one port's pins as sampled by the system clock
   typedef struct packed {
      logic clk;
      logic rst_n;
      logic cs_n;
      logic wr_sel;
      logic wen;
      logic ren;
      logic pen_n;
      logic [DATA_W-1:0] data;
   } dcbff_pins_t;

   // binary to gray
   function automatic logic [ADDR_W:0] dcbff_bin2gray(input logic [ADDR_W:0] b);
      return b ^ (b >> 1);
   endfunction

   // gray to binary
   function automatic logic [ADDR_W:0] dcbff_gray2bin(input logic [ADDR_W:0] g);
      logic [ADDR_W:0] b;
      b = '0;
      for (int i = ADDR_W; i >= 0; i--) begin
         b[i] = (i == ADDR_W) ? g[i] : (b[i+1] ^ g[i]);
      end
      return b;
   endfunction
endpackage

/* File: logic/dcbff_queue.sv */
// one direction of the fifo: storage, pointers, ready and level flags, offsets
// assumes write and read edges are one-cycle enables on clk_sys from the top
`timescale 1ns/100ps
module dcbff_queue
   import dcbff_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   // system clock and power-on reset
   input wire logic clk_sys,
   input wire logic resetn,
   // queue reset level, synchronised
   input wire logic q_reset_n,
   // writer side
   input wire logic wr_edge,
   input wire logic wr_req,
   input wire logic prog_n,
   input wire logic [WIDTH-1:0] wr_data,
   // reader side
   input wire logic rd_edge,
   input wire logic rd_req,
   // flags and output register
   output logic input_ready,
   output logic output_ready,
   output logic half_full,
   output logic almost_flag,
   output logic [WIDTH-1:0] out_word
);
   logic [WIDTH-1:0] mem [DEPTH]; // storage array
   logic [ADDR_W:0] wp_q, wp_d, rp_q, rp_d; // binary pointers
   logic [ADDR_W:0] wg_q, wg_d, wg_s1_q, wg_s1_d, wg_s2_q, wg_s2_d; // write gray
   logic [ADDR_W:0] rg_q, rg_d, rg_s1_q, rg_s1_d, rg_s2_q, rg_s2_d; // read gray
   logic arm_q, arm_d, ir_q, ir_d, or_q, or_d; // ready state
   logic hf_q, hf_d, af_q, af_d; // level flags
   logic open_q, open_d; // programming window
   logic [1:0] pcnt_q, pcnt_d; // program edge count
   logic [OFFSET_W-1:0] x_q, x_d, y_q, y_d; // offsets
   logic [WIDTH-1:0] ow_q, ow_d; // output register
   logic push, pop, load, prog_edge, full_now; // helpers
   logic [ADDR_W:0] rp_w, wp_r, level, used_after;

   // pointer views on the far side, and push/pop decode
   always_comb begin
      rp_w = dcbff_gray2bin(rg_s2_q);
      wp_r = dcbff_gray2bin(wg_s2_q);
      level = wp_q - rp_w;
      full_now = (level == FULL_LEVEL);
      prog_edge = wr_edge && !prog_n && open_q && (pcnt_q != PROG_DONE);
      push = wr_edge && wr_req && ir_q && !full_now && !prog_edge;
      pop = rd_edge && rd_req && or_q;
      load = rd_edge && (wp_r != rp_q) && (!or_q || rd_req);
   end

   // next state of pointers, ready flags, offsets and level flags
   always_comb begin
      wp_d = wp_q + {{ADDR_W{1'b0}}, push};
      rp_d = rp_q + {{ADDR_W{1'b0}}, load};
      wg_d = dcbff_bin2gray(wp_d);
      rg_d = dcbff_bin2gray(rp_d);
      // two-stage crossings, each stepped by the far port's edge
      wg_s1_d = rd_edge ? wg_q : wg_s1_q;
      wg_s2_d = rd_edge ? wg_s1_q : wg_s2_q;
      rg_s1_d = wr_edge ? rg_q : rg_s1_q;
      rg_s2_d = wr_edge ? rg_s1_q : rg_s2_q;
      used_after = level + {{ADDR_W{1'b0}}, push};
      // writer: arm on first edge, ready on second, drop when full
      arm_d = arm_q | wr_edge;
      ir_d = wr_edge ? (arm_q && (used_after != FULL_LEVEL)) : ir_q;
      // reader: fall through when idle, hold last word when drained
      or_d = or_q;
      ow_d = ow_q;
      if (load) begin
         or_d = 1'b1;
         ow_d = mem[rp_q[ADDR_W-1:0]];
      end else if (pop) begin
         or_d = 1'b0;
      end
      // offset programming
      open_d = open_q && !push;
      pcnt_d = pcnt_q;
      x_d = x_q;
      y_d = y_q;
      if (wr_edge && prog_n) begin
         pcnt_d = 2'h0;
      end else if (prog_edge) begin
         pcnt_d = pcnt_q + 2'h1;
         y_d = wr_data[OFFSET_W-1:0];
         if (pcnt_q == 2'h0) begin
            x_d = wr_data[OFFSET_W-1:0];
         end
      end
      // level flags from the crossed read pointer
      hf_d = (level >= HALF_LEVEL);
      af_d = (level <= {2'b00, x_q}) ||
             (level >= (FULL_LEVEL - {2'b00, y_q}));
      // queue reset overrides all state here except the output word
      if (!q_reset_n) begin
         wp_d = '0;
         rp_d = '0;
         wg_d = '0;
         rg_d = '0;
         wg_s1_d = '0;
         wg_s2_d = '0;
         rg_s1_d = '0;
         rg_s2_d = '0;
         arm_d = 1'b0;
         ir_d = 1'b0;
         or_d = 1'b0;
         hf_d = 1'b0;
         af_d = 1'b1;
         open_d = 1'b1;
         pcnt_d = 2'h0;
         x_d = OFFSET_DEFAULT;
         y_d = OFFSET_DEFAULT;
      end
   end

   // storage write, no reset on the array
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp_q[ADDR_W-1:0]] <= wr_data;
      end
   end

   // state registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wp_q <= '0;
         rp_q <= '0;
         wg_q <= '0;
         rg_q <= '0;
         wg_s1_q <= '0;
         wg_s2_q <= '0;
         rg_s1_q <= '0;
         rg_s2_q <= '0;
         arm_q <= 1'b0;
         ir_q <= 1'b0;
         or_q <= 1'b0;
         hf_q <= 1'b0;
         af_q <= 1'b1;
         open_q <= 1'b1;
         pcnt_q <= 2'h0;
         x_q <= OFFSET_DEFAULT;
         y_q <= OFFSET_DEFAULT;
         ow_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         wg_q <= wg_d;
         rg_q <= rg_d;
         wg_s1_q <= wg_s1_d;
         wg_s2_q <= wg_s2_d;
         rg_s1_q <= rg_s1_d;
         rg_s2_q <= rg_s2_d;
         arm_q <= arm_d;
         ir_q <= ir_d;
         or_q <= or_d;
         hf_q <= hf_d;
         af_q <= af_d;
         open_q <= open_d;
         pcnt_q <= pcnt_d;
         x_q <= x_d;
         y_q <= y_d;
         ow_q <= ow_d;
      end
   end

   // outputs straight from flops
   assign input_ready = ir_q;
   assign output_ready = or_q;
   assign half_full = hf_q;
   assign almost_flag = af_q;
   assign out_word = ow_q;
endmodule

/* File: logic/dcbff_top.sv */
// bidirectional fifo top: pin sampling, port edge enables, two queues, data drive
// assumes port clocks are much slower than clk_sys and all pins are asynchronous
`timescale 1ns/100ps
module dcbff_top
   import dcbff_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // port a pins
   input wire logic port_a_clock,
   input wire logic queue_a_to_b_reset_n,
   input wire logic chip_select_port_a_n,
   input wire logic write_read_select_a,
   input wire logic write_enable_port_a,
   input wire logic read_enable_port_a,
   input wire logic offset_program_enable_a_n,
   input wire logic [DATA_W-1:0] port_a_data_in,
   output logic [DATA_W-1:0] port_a_data_out,
   output logic port_a_data_oe_n,
   // port b pins
   input wire logic port_b_clock,
   input wire logic queue_b_to_a_reset_n,
   input wire logic chip_select_port_b_n,
   input wire logic write_read_select_b,
   input wire logic write_enable_port_b,
   input wire logic read_enable_port_b,
   input wire logic offset_program_enable_b_n,
   input wire logic [DATA_W-1:0] port_b_data_in,
   output logic [DATA_W-1:0] port_b_data_out,
   output logic port_b_data_oe_n,
   // flags
   output logic input_ready_port_a,
   output logic output_ready_port_a,
   output logic input_ready_port_b,
   output logic output_ready_port_b,
   output logic half_full_a_to_b,
   output logic half_full_b_to_a,
   output logic almost_level_flag_a_to_b,
   output logic almost_level_flag_b_to_a
);
   dcbff_pins_t pins_raw [2]; // raw pins, index 0 = port a
   dcbff_pins_t pins_s1_q [2]; // first sampling stage
   dcbff_pins_t pins_s2_q [2]; // second stage, safe to read
   logic clk_s3_q [2]; // delayed clock for edge detect
   logic edge_p [2]; // rising edge enable per port
   logic wr_req [2]; // write selected per port
   logic rd_req [2]; // read selected per port
   logic qrst_n [2]; // queue reset, index = feeding port
   logic oe_n_d [2]; // next output enable
   logic oe_n_q [2]; // registered output enable
   logic [DATA_W-1:0] qout [2]; // output word of queue fed by port
   logic ir [2]; // input ready of queue fed by port
   logic orr [2]; // output ready of queue fed by port
   logic hf [2]; // half full of queue fed by port
   logic af [2]; // almost flag of queue fed by port

   // gather pins into bundles
   always_comb begin
      pins_raw[0] = '{port_a_clock, queue_a_to_b_reset_n, chip_select_port_a_n,
                      write_read_select_a, write_enable_port_a, read_enable_port_a,
                      offset_program_enable_a_n, port_a_data_in};
      pins_raw[1] = '{port_b_clock, queue_b_to_a_reset_n, chip_select_port_b_n,
                      write_read_select_b, write_enable_port_b, read_enable_port_b,
                      offset_program_enable_b_n, port_b_data_in};
   end

   // per-port sampling, edge detect and decode
   for (genvar p = 0; p < 2; p++) begin : g_port
      // two-flop sampling of every pin, third flop for the clock edge
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            pins_s1_q[p] <= '{clk: 1'b0, rst_n: 1'b0, cs_n: 1'b1, wr_sel: 1'b1,
                              wen: 1'b0, ren: 1'b0, pen_n: 1'b1, data: '0};
            pins_s2_q[p] <= '{clk: 1'b0, rst_n: 1'b0, cs_n: 1'b1, wr_sel: 1'b1,
                              wen: 1'b0, ren: 1'b0, pen_n: 1'b1, data: '0};
            clk_s3_q[p] <= 1'b0;
            oe_n_q[p] <= 1'b1;
         end else begin
            pins_s1_q[p] <= pins_raw[p];
            pins_s2_q[p] <= pins_s1_q[p];
            clk_s3_q[p] <= pins_s2_q[p].clk;
            oe_n_q[p] <= oe_n_d[p];
         end
      end

      // edge enable and request decode
      always_comb begin
         edge_p[p] = pins_s2_q[p].clk && !clk_s3_q[p];
         wr_req[p] = !pins_s2_q[p].cs_n && pins_s2_q[p].wr_sel && pins_s2_q[p].wen;
         rd_req[p] = !pins_s2_q[p].cs_n && !pins_s2_q[p].wr_sel && pins_s2_q[p].ren;
         oe_n_d[p] = pins_s2_q[p].cs_n || pins_s2_q[p].wr_sel;
         qrst_n[p] = pins_s2_q[p].rst_n;
      end

      // queue fed by port p, drained by the other port
      dcbff_queue #(
         .WIDTH(DATA_W)
      ) u_queue (
         .clk_sys(clk_sys),
         .resetn(resetn),
         .q_reset_n(qrst_n[p]),
         .wr_edge(edge_p[p]),
         .wr_req(wr_req[p]),
         .prog_n(pins_s2_q[p].pen_n),
         .wr_data(pins_s2_q[p].data),
         .rd_edge(edge_p[1-p]),
         .rd_req(rd_req[1-p]),
         .input_ready(ir[p]),
         .output_ready(orr[p]),
         .half_full(hf[p]),
         .almost_flag(af[p]),
         .out_word(qout[p])
      );
   end

   // outputs, each from a flop inside the queues or here
   assign port_a_data_out = qout[1];
   assign port_b_data_out = qout[0];
   assign port_a_data_oe_n = oe_n_q[0];
   assign port_b_data_oe_n = oe_n_q[1];
   assign input_ready_port_a = ir[0];
   assign input_ready_port_b = ir[1];
   assign output_ready_port_a = orr[1];
   assign output_ready_port_b = orr[0];
   assign half_full_a_to_b = hf[0];
   assign half_full_b_to_a = hf[1];
   assign almost_level_flag_a_to_b = af[0];
   assign almost_level_flag_b_to_a = af[1];
endmodule

/* File: verif/dcbff_top_assertions.sv */
// checker for the bidirectional fifo top: reset, ready edges, drive and hold
// assumes it is bound into dcbff_top and sees only that module's pins
`timescale 1ns/100ps
module dcbff_top_checker
   import dcbff_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // port pins
   input wire logic port_a_clock,
   input wire logic port_b_clock,
   input wire logic queue_a_to_b_reset_n,
   input wire logic queue_b_to_a_reset_n,
   input wire logic chip_select_port_a_n,
   input wire logic write_read_select_a,
   input wire logic chip_select_port_b_n,
   input wire logic write_read_select_b,
   // design outputs
   input wire logic [DATA_W-1:0] port_a_data_out,
   input wire logic [DATA_W-1:0] port_b_data_out,
   input wire logic port_a_data_oe_n,
   input wire logic port_b_data_oe_n,
   input wire logic input_ready_port_a,
   input wire logic output_ready_port_a,
   input wire logic input_ready_port_b,
   input wire logic output_ready_port_b,
   input wire logic half_full_a_to_b,
   input wire logic half_full_b_to_a,
   input wire logic almost_level_flag_a_to_b,
   input wire logic almost_level_flag_b_to_a
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // data pins driven only when selected for read, three cycles on
   drive_pa_a: assert property ($past(resetn, 5) |->
      port_a_data_oe_n == ($past(chip_select_port_a_n, 3) || $past(write_read_select_a, 3)))
      else $error("port a drive mismatch");
   drive_pb_a: assert property ($past(resetn, 5) |->
      port_b_data_oe_n == ($past(chip_select_port_b_n, 3) || $past(write_read_select_b, 3)))
      else $error("port b drive mismatch");
   // flags held at reset values while a queue reset is held
   reset_ab_a: assert property (!queue_a_to_b_reset_n [*6] |-> !input_ready_port_a
      && !output_ready_port_b && !half_full_a_to_b && almost_level_flag_a_to_b)
      else $error("queue a to b reset flags wrong");
   reset_ba_a: assert property (!queue_b_to_a_reset_n [*6] |-> !input_ready_port_b
      && !output_ready_port_a && !half_full_b_to_a && almost_level_flag_b_to_a)
      else $error("queue b to a reset flags wrong");
   // ready flags rise only just after a rise of their port clock
   ready_edge_a: assert property ($rose(input_ready_port_a) |-> $past(port_a_clock, 2)
      || $past(port_a_clock, 3) || $past(port_a_clock, 4))
      else $error("input ready a rose off its clock");
   fill_edge_a: assert property ($rose(output_ready_port_b) |-> $past(port_b_clock, 2)
      || $past(port_b_clock, 3) || $past(port_b_clock, 4))
      else $error("output ready b rose off its clock");
   // last word stays put while output ready is low
   hold_pb_a: assert property (!output_ready_port_b && !$past(output_ready_port_b)
      && queue_a_to_b_reset_n && $past(queue_a_to_b_reset_n, 6) |-> $stable(port_b_data_out))
      else $error("port b word moved while empty");
   hold_pa_a: assert property (!output_ready_port_a && !$past(output_ready_port_a)
      && queue_b_to_a_reset_n && $past(queue_b_to_a_reset_n, 6) |-> $stable(port_a_data_out))
      else $error("port a word moved while empty");
endmodule

/* File: verif/dcbff_port_model.sv */
// far-side model: free-running port clocks and the queue reset sequence
// assumes the bench pulses rst_go for one clk_sys cycle
`timescale 1ns/100ps
module dcbff_port_model (
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // bench request
   input wire logic rst_go,
   // port clocks and queue resets
   output logic [1:0] ck,
   output logic [1:0] qrn
);
   logic [2:0] da, db; // clock dividers
   logic [2:0] na, nb; // port clock rises seen in reset
   logic busy; // queue reset in progress
   // half periods 6 and 5 cycles keep the two ports unrelated
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {ck, qrn, da, db, na, nb, busy} <= {2'h0, 2'h3, 12'h000, 1'b0};
      end else begin
         da <= (da == 3'h5) ? 3'h0 : da + 3'h1;
         db <= (db == 3'h4) ? 3'h0 : db + 3'h1;
         ck <= ck ^ {db == 3'h4, da == 3'h5};
         if (rst_go) begin
            {busy, qrn, na, nb} <= {1'b1, 2'h0, 6'h00};
         end else if (busy) begin
            na <= na + 3'(da == 3'h5 && !ck[0]);
            nb <= nb + 3'(db == 3'h4 && !ck[1]);
            // release on a port a fall after four rises of each clock
            if (da == 3'h5 && ck[0] && na >= 3'h4 && nb >= 3'h4) begin
               {busy, qrn} <= {1'b0, 2'h3};
            end
         end
      end
   end
endmodule

/* File: verif/dcbff_top_tb.sv */
// self-checking bench for the bidirectional fifo top
// assumes the port model makes the port clocks and queue resets
`timescale 1ns/100ps
module dcbff_top_tb;
   import dcbff_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic rst_go = 1'b0;
   dcbff_pins_t pin [2]; // bench-driven port pins
   wire [1:0] ck, qrn, oen, ir, orr, hf, af;
   wire [DATA_W-1:0] dout [2];
   logic [DATA_W-1:0] exp_q [$]; // words due on port b
   logic [DATA_W-1:0] exp_a [$]; // first two words due on port a
   logic [DATA_W-1:0] prev_d = '0;
   logic [DATA_W-1:0] e_w, w;
   logic prev_or = 1'b0;
   int miscompares = 0;
   int n_checks = 0;
   dcbff_port_model host (.clk_sys(clk_sys), .resetn(resetn), .rst_go(rst_go), .ck(ck),
      .qrn(qrn));
   dcbff_top dut (.clk_sys(clk_sys), .resetn(resetn),
      .port_a_clock(ck[0]), .queue_a_to_b_reset_n(qrn[0]),
      .chip_select_port_a_n(pin[0].cs_n), .write_read_select_a(pin[0].wr_sel),
      .write_enable_port_a(pin[0].wen), .read_enable_port_a(pin[0].ren),
      .offset_program_enable_a_n(pin[0].pen_n), .port_a_data_in(pin[0].data),
      .port_a_data_out(dout[0]), .port_a_data_oe_n(oen[0]),
      .port_b_clock(ck[1]), .queue_b_to_a_reset_n(qrn[1]),
      .chip_select_port_b_n(pin[1].cs_n), .write_read_select_b(pin[1].wr_sel),
      .write_enable_port_b(pin[1].wen), .read_enable_port_b(pin[1].ren),
      .offset_program_enable_b_n(pin[1].pen_n), .port_b_data_in(pin[1].data),
      .port_b_data_out(dout[1]), .port_b_data_oe_n(oen[1]),
      .input_ready_port_a(ir[0]), .output_ready_port_a(orr[0]),
      .input_ready_port_b(ir[1]), .output_ready_port_b(orr[1]),
      .half_full_a_to_b(hf[0]), .half_full_b_to_a(hf[1]),
      .almost_level_flag_a_to_b(af[0]), .almost_level_flag_b_to_a(af[1]));
   initial forever #20 clk_sys = ~clk_sys;
   task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one falling edge of a port clock
   task automatic edg(input int p);
      if (p == 1) @(negedge ck[1]);
      else @(negedge ck[0]);
   endtask
   // controls {cs_n, wr_sel, wen, ren, pen_n}
   task automatic drv(input int p, input logic [4:0] c, input logic [DATA_W-1:0] d);
      pin[p] <= {2'b00, c, d};
   endtask
   task automatic wr(input int p, input logic [DATA_W-1:0] d, input bit keep);
      edg(p);
      drv(p, 5'b01101, d);
      if (keep) exp_q.push_back(d);
      edg(p);
      drv(p, 5'b10001, d);
   endtask
   // settle, then level flags; word in the output register is not counted
   task automatic lvl(input int p, input int n, input int x, input int y);
      int l;
      l = (n > 0) ? n - 1 : 0;
      repeat (6) edg(p);
      chk("half", 18'(l >= 256), 18'(hf[p]));
      chk("almost", 18'(l <= x || l >= 512 - y), 18'(af[p]));
   endtask
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // pairs each fresh word on port b with the oldest note
   always @(posedge clk_sys) begin
      if (orr[1] === 1'b1 && (prev_or !== 1'b1 || dout[1] !== prev_d)) begin
         e_w = (exp_q.size() > 0) ? exp_q.pop_front() : ~dout[1];
         chk("word b", e_w, dout[1]);
      end
      prev_or <= orr[1];
      prev_d <= dout[1];
   end
   initial begin
      #3600000;
      miscompares++;
      give_verdict();
   end
   initial begin
      pin[0] = {2'b00, 5'b10001, 18'h00000};
      pin[1] = {2'b00, 5'b10001, 18'h00000};
      void'($urandom(32'hB26BD420));
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      rst_go <= 1'b1;
      @(posedge clk_sys);
      rst_go <= 1'b0;
      repeat (3) edg(0);
      chk("reset flags", 18'h00003, 18'({ir, orr, hf, af}));
      @(posedge qrn[0]);
      @(posedge ck[0]);
      edg(0);
      chk("ready a edge 1", 18'h0, 18'(ir[0]));
      @(posedge ck[0]);
      edg(0);
      chk("ready a edge 2", 18'h1, 18'(ir[0]));
      $display("test reset done");
      // program x=2 then y=4 with write controls also set
      drv(0, 5'b01100, 18'h3FF02);
      edg(0);
      drv(0, 5'b01100, 18'h3FF04);
      edg(0);
      drv(0, 5'b10001, 18'h00000);
      for (int n = 1; n <= 513; n++) begin
         w = {10'($urandom()), 8'(n)};
         wr(0, w, 1'b1);
         lvl(0, n, 2, 4);
      end
      chk("ready a full", 18'h0, 18'(ir[0]));
      wr(0, 18'h3FFFF, 1'b0);
      $display("test fill a done");
      edg(1);
      drv(1, 5'b00011, 18'h00000);
      repeat (530) edg(1);
      drv(1, 5'b10001, 18'h00000);
      lvl(0, 0, 2, 4);
      chk("words left", 18'h0, 18'(exp_q.size()));
      chk("ready b empty", 18'h0, 18'(orr[1]));
      $display("test drain b done");
      drv(0, 5'b00001, 18'h00000);
      for (int n = 1; n <= 130; n++) begin
         w = 18'($urandom());
         if (n <= 2) exp_a.push_back(w);
         wr(1, w, 1'b0);
         lvl(1, n, 128, 128);
      end
      chk("drive a", 18'h0, 18'(oen[0]));
      chk("drive b", 18'h1, 18'(oen[1]));
      chk("ready a out", 18'h1, 18'(orr[0]));
      chk("word a", exp_a[0], dout[0]);
      // one read on port a pops the fall-through word and loads the next
      edg(0);
      drv(0, 5'b00011, 18'h00000);
      edg(0);
      drv(0, 5'b00001, 18'h00000);
      edg(0);
      chk("word a next", exp_a[1], dout[0]);
      chk("ready a kept", 18'h1, 18'(orr[0]));
      $display("test defaults b done");
      give_verdict();
   end
endmodule
bind dcbff_top dcbff_top_checker chk_u (.*);
